/* hw/pin_event_pkg.sv */
// shared types and constants for the pin event interrupt logic
package pin_event_pkg;

   // external line sense codes (sense bit1, sense bit0)
   localparam logic [1:0] SENSE_LOW     = 2'h0;
   localparam logic [1:0] SENSE_CHANGE  = 2'h1;
   localparam logic [1:0] SENSE_FALLING = 2'h2;
   localparam logic [1:0] SENSE_RISING  = 2'h3;

   // reset values
   localparam logic       EXT_FLAG_RESET    = 1'b0;
   localparam logic       PINCHG_FLAG_RESET = 1'b0;
   localparam logic [7:0] SYNC_RESET        = 8'hff;

   // port A monitored line positions
   localparam int PA_LINE3 = 3;
   localparam int PA_LINE6 = 6;
   localparam int PA_LINE7 = 7;

   // serial wire mode codes (hi, lo)
   localparam logic [1:0] WIRE_MODE_THREE = 2'h1;

   // compare mode plus pwm code that selects the inverted output
   localparam logic [2:0] CMP_PWM_INV_OUT = 3'h3;

   // pll fuse plus clock select fuse codes
   localparam logic [4:0] CLK_LINE4_EXACT = 5'h10;
   localparam logic [4:0] CLK_LINE4_LOW   = 5'h15;
   localparam logic [4:0] CLK_LINE5_LOW   = 5'h19;

   // external interrupt enable plus sense bits that claim line 6
   localparam logic [2:0] EXT_CLAIM_CODE = 3'h4;
   localparam logic [1:0] T0_EXT_CLOCK   = 2'h3;

   // wake-up needs this many agreeing watchdog samples
   localparam int WAKE_SAMPLES = 2;

   // alternate function control bits gathered together
   typedef struct packed {
      logic       analog_ref_select;
      logic       comparator_disable;
      logic       serial_wire_mode_hi;
      logic       serial_wire_mode_lo;
      logic       chan_a_compare_mode_hi;
      logic       chan_a_compare_mode_lo;
      logic       chan_a_pwm_en;
      logic       chan_b_compare_mode_hi;
      logic       chan_b_compare_mode_lo;
      logic       chan_b_pwm_en;
      logic       pll_clock_fuse;
      logic [3:0] clock_select_fuses;
      logic       t0_clock_sel2;
      logic       t0_clock_sel1;
      logic       reset_pin_disable_fuse;
   } alt_ctrl_t;

   // external line configuration from the processor control register
   typedef struct packed {
      logic       ext_irq_en;
      logic [1:0] sense;
   } ext_cfg_t;

endpackage

/* hw/line_sync.sv */
// two flip-flop synchroniser with change detection per line
`timescale 1ns/1ps
`default_nettype none
module line_sync
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic [WIDTH-1:0] line_in,
   output logic      [WIDTH-1:0] level_out,
   output logic      [WIDTH-1:0] changed_out
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] prev_r;

   if (WIDTH < 1)
   begin : g_bad_width
      $error("line_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         meta_r <= {WIDTH{1'b1}};
         sync_r <= {WIDTH{1'b1}};
         prev_r <= {WIDTH{1'b1}};
      end
      else
      begin
         meta_r <= line_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level_out   = sync_r;
   assign changed_out = sync_r ^ prev_r;

endmodule
`default_nettype wire

/* hw/wake_sampler.sv */
// wake-up level qualifier sampled on watchdog oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module wake_sampler
#(
   parameter int SAMPLES = pin_event_pkg::WAKE_SAMPLES
)
(
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic wdt_tick_in,
   input  wire logic armed_in,
   input  wire logic level_ok_in,
   output logic      wake_out
);

   localparam int CW = $clog2(SAMPLES + 1);

   logic [CW-1:0] count_r;
   logic          wake_r;

   if (SAMPLES < 1)
   begin : g_bad_samples
      $error("wake_sampler: SAMPLES must be at least 1");
   end

   // consecutive tick samples at required level
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         count_r <= '0;
      end
      else if (!armed_in)
      begin
         count_r <= '0;
      end
      else if (wdt_tick_in)
      begin
         if (!level_ok_in)
         begin
            count_r <= '0;
         end
         else if (count_r != CW'(SAMPLES))
         begin
            count_r <= count_r + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         wake_r <= 1'b0;
      end
      else
      begin
         wake_r <= armed_in && (count_r == CW'(SAMPLES));
      end
   end

   assign wake_out = wake_r;

endmodule
`default_nettype wire

/* hw/pin_event_interrupt_logic.sv */
// external line and pin change interrupt request logic
`timescale 1ns/1ps
`default_nettype none
module pin_event_interrupt_logic
(
   input  wire logic                     CLK_IN,
   input  wire logic                     RST_B_IN,
   input  wire logic [7:0]               PORT_A_IN,
   input  wire logic [7:0]               PORT_B_IN,
   input  wire logic                     EXT_IRQ_LINE_IN,
   input  wire pin_event_pkg::ext_cfg_t  EXT_CFG_IN,
   input  wire logic                     PINCHG_UPPER_GROUP_EN_IN,
   input  wire logic                     PINCHG_LOWER_GROUP_EN_IN,
   input  wire pin_event_pkg::alt_ctrl_t ALT_CTRL_IN,
   input  wire logic                     EXT_FLAG_CLEAR_IN,
   input  wire logic                     EXT_VECTOR_TAKEN_IN,
   input  wire logic                     PINCHG_FLAG_CLEAR_IN,
   input  wire logic                     PINCHG_VECTOR_TAKEN_IN,
   input  wire logic                     SLEEP_IN,
   input  wire logic                     WDT_TICK_IN,
   output logic                          EXT_FLAG_OUT,
   output logic                          EXT_IRQ_REQ_OUT,
   output logic                          PINCHG_FLAG_OUT,
   output logic                          PINCHG_IRQ_REQ_OUT,
   output logic                          WAKE_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks on shared constants

   if (pin_event_pkg::PA_LINE3 > 7 || pin_event_pkg::PA_LINE6 > 7
       || pin_event_pkg::PA_LINE7 > 7)
   begin : g_bad_line
      $error("pin_event_interrupt_logic: port A line position out of range");
   end

   if (pin_event_pkg::WAKE_SAMPLES < 1)
   begin : g_bad_wake
      $error("pin_event_interrupt_logic: wake needs at least one sample");
   end

   ////////////////////////////////////////////////////////////////////////////
   // synchronised lines

   logic [7:0] a_level;
   logic [7:0] a_changed;
   logic [7:0] b_level;
   logic [7:0] b_changed;
   logic [7:0] ext_level_vec;
   logic [7:0] ext_changed_vec;
   logic       ext_level;
   logic       ext_changed;
   logic       ext_level_prev;

   line_sync #(.WIDTH(8)) sync_port_a
   (
      .clk_in      (CLK_IN),
      .rst_b_in    (RST_B_IN),
      .line_in     (PORT_A_IN),
      .level_out   (a_level),
      .changed_out (a_changed)
   );

   line_sync #(.WIDTH(8)) sync_port_b
   (
      .clk_in      (CLK_IN),
      .rst_b_in    (RST_B_IN),
      .line_in     (PORT_B_IN),
      .level_out   (b_level),
      .changed_out (b_changed)
   );

   line_sync #(.WIDTH(8)) sync_ext
   (
      .clk_in      (CLK_IN),
      .rst_b_in    (RST_B_IN),
      .line_in     ({7'h7f, EXT_IRQ_LINE_IN}),
      .level_out   (ext_level_vec),
      .changed_out (ext_changed_vec)
   );

   assign ext_level      = ext_level_vec[0];
   assign ext_changed    = ext_changed_vec[0];
   assign ext_level_prev = ext_level ^ ext_changed;

   ////////////////////////////////////////////////////////////////////////////
   // synchronised watchdog tick

   logic wdt_meta_r;
   logic wdt_sync_r;
   logic wdt_prev_r;
   logic wdt_tick;

   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         wdt_meta_r <= 1'b0;
         wdt_sync_r <= 1'b0;
         wdt_prev_r <= 1'b0;
      end
      else
      begin
         wdt_meta_r <= WDT_TICK_IN;
         wdt_sync_r <= wdt_meta_r;
         wdt_prev_r <= wdt_sync_r;
      end
   end

   assign wdt_tick = wdt_sync_r && !wdt_prev_r;

   ////////////////////////////////////////////////////////////////////////////
   // external line event selection

   logic ext_event;
   logic ext_level_req;
   logic ext_level_mode;
   logic ext_fall;
   logic ext_rise;

   assign ext_level_mode = (EXT_CFG_IN.sense == pin_event_pkg::SENSE_LOW);
   // previous sample high means the change was a falling edge
   assign ext_fall       = ext_changed && ext_level_prev;
   assign ext_rise       = ext_changed && !ext_level_prev;

   always_comb
   begin
      // the line is read back from the pin, so driving it as output still counts
      case (EXT_CFG_IN.sense)
         pin_event_pkg::SENSE_LOW:     ext_event = !ext_level;
         pin_event_pkg::SENSE_CHANGE:  ext_event = ext_changed;
         pin_event_pkg::SENSE_FALLING: ext_event = ext_fall;
         default:                      ext_event = ext_rise;
      endcase
   end

   // level mode requests directly while low
   assign ext_level_req = EXT_CFG_IN.ext_irq_en && ext_level_mode && !ext_level;

   ////////////////////////////////////////////////////////////////////////////
   // external flag

   logic ext_flag_r;
   logic ext_clear;

   // software write-one or vector entry
   assign ext_clear = EXT_FLAG_CLEAR_IN || EXT_VECTOR_TAKEN_IN;

   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         ext_flag_r <= pin_event_pkg::EXT_FLAG_RESET;
      end
      else if (ext_level_mode)
      begin
         // flag reads cleared in level mode
         ext_flag_r <= 1'b0;
      end
      else if (ext_event)
      begin
         ext_flag_r <= 1'b1;
      end
      else if (ext_clear)
      begin
         ext_flag_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // alternate function masks

   logic [7:0]  b_mask;
   logic [7:0]  a_mask;
   logic [1:0]  wire_mode;
   logic [4:0]  clk_fuses;
   logic [2:0]  chan_a_code;
   logic [2:0]  chan_b_code;
   logic [2:0]  ext_claim;
   logic        two_wire;
   logic        three_wire;
   logic        chan_a_inv_out;
   logic        chan_b_inv_out;
   logic        chan_a_out;
   logic        chan_b_out;
   logic        xtal_in_clock;
   logic        xtal_out_clock;
   logic        ext_claims_line;
   logic        t0_ext_clock;

   assign wire_mode   = {ALT_CTRL_IN.serial_wire_mode_hi, ALT_CTRL_IN.serial_wire_mode_lo};
   assign clk_fuses   = {ALT_CTRL_IN.pll_clock_fuse, ALT_CTRL_IN.clock_select_fuses};
   assign chan_a_code = {ALT_CTRL_IN.chan_a_compare_mode_hi, ALT_CTRL_IN.chan_a_compare_mode_lo,
                         ALT_CTRL_IN.chan_a_pwm_en};
   assign chan_b_code = {ALT_CTRL_IN.chan_b_compare_mode_hi, ALT_CTRL_IN.chan_b_compare_mode_lo,
                         ALT_CTRL_IN.chan_b_pwm_en};
   assign ext_claim   = {EXT_CFG_IN.ext_irq_en, EXT_CFG_IN.sense};

   assign two_wire        = ALT_CTRL_IN.serial_wire_mode_hi;
   assign three_wire      = (wire_mode == pin_event_pkg::WIRE_MODE_THREE);
   assign chan_a_inv_out  = (chan_a_code == pin_event_pkg::CMP_PWM_INV_OUT);
   assign chan_b_inv_out  = (chan_b_code == pin_event_pkg::CMP_PWM_INV_OUT);
   assign chan_a_out      = ALT_CTRL_IN.chan_a_compare_mode_hi
                            || ALT_CTRL_IN.chan_a_compare_mode_lo;
   assign chan_b_out      = ALT_CTRL_IN.chan_b_compare_mode_hi
                            || ALT_CTRL_IN.chan_b_compare_mode_lo;
   assign xtal_in_clock   = (clk_fuses == pin_event_pkg::CLK_LINE4_EXACT)
                            || (clk_fuses >= pin_event_pkg::CLK_LINE4_LOW);
   assign xtal_out_clock  = (clk_fuses >= pin_event_pkg::CLK_LINE5_LOW);
   assign ext_claims_line = (ext_claim == pin_event_pkg::EXT_CLAIM_CODE);
   assign t0_ext_clock    = ({ALT_CTRL_IN.t0_clock_sel2, ALT_CTRL_IN.t0_clock_sel1}
                             == pin_event_pkg::T0_EXT_CLOCK);

   always_comb
   begin
      a_mask = 8'h00;
      a_mask[pin_event_pkg::PA_LINE3] = ALT_CTRL_IN.analog_ref_select;
      a_mask[pin_event_pkg::PA_LINE6] = !ALT_CTRL_IN.comparator_disable;
      a_mask[pin_event_pkg::PA_LINE7] = !ALT_CTRL_IN.comparator_disable;
   end

   // each condition alone claims the line
   always_comb
   begin
      b_mask[0] = two_wire || three_wire || chan_a_inv_out;
      b_mask[1] = three_wire || chan_a_out;
      b_mask[2] = two_wire || three_wire || chan_b_inv_out;
      b_mask[3] = chan_b_out;
      b_mask[4] = xtal_in_clock;
      b_mask[5] = xtal_out_clock;
      b_mask[6] = ext_claims_line || t0_ext_clock;
      b_mask[7] = ALT_CTRL_IN.reset_pin_disable_fuse;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin change event gathering

   logic [7:0] b_group_en;
   logic [7:0] a_group_en;
   logic [7:0] b_hit;
   logic [7:0] a_hit;
   logic       pinchg_event;

   // upper group: B7-4 and A7, A6, A3; lower group: B3-0
   assign b_group_en = {{4{PINCHG_UPPER_GROUP_EN_IN}}, {4{PINCHG_LOWER_GROUP_EN_IN}}};

   always_comb
   begin
      a_group_en = 8'h00;
      a_group_en[pin_event_pkg::PA_LINE3] = PINCHG_UPPER_GROUP_EN_IN;
      a_group_en[pin_event_pkg::PA_LINE6] = PINCHG_UPPER_GROUP_EN_IN;
      a_group_en[pin_event_pkg::PA_LINE7] = PINCHG_UPPER_GROUP_EN_IN;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_hit
         // sampled pin level includes lines the device drives itself
         assign b_hit[gi] = b_changed[gi] && b_group_en[gi] && !b_mask[gi];
         assign a_hit[gi] = a_changed[gi] && a_group_en[gi] && !a_mask[gi];
      end
   endgenerate

   // independent of the external line flag, so one edge can set both
   assign pinchg_event = |{b_hit, a_hit};

   ////////////////////////////////////////////////////////////////////////////
   // pin change flag

   logic pinchg_flag_r;
   logic pinchg_clear;

   // software write-one or vector entry
   assign pinchg_clear = PINCHG_FLAG_CLEAR_IN || PINCHG_VECTOR_TAKEN_IN;

   always_ff @(posedge CLK_IN or negedge RST_B_IN)
   begin
      if (!RST_B_IN)
      begin
         pinchg_flag_r <= pin_event_pkg::PINCHG_FLAG_RESET;
      end
      else if (pinchg_event)
      begin
         pinchg_flag_r <= 1'b1;
      end
      else if (pinchg_clear)
      begin
         pinchg_flag_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wake-up qualification

   logic wake_armed;
   logic wake_level_ok;

   assign wake_armed    = SLEEP_IN && EXT_CFG_IN.ext_irq_en;
   assign wake_level_ok = ext_level_mode ? !ext_level : ext_flag_r;

   wake_sampler #(.SAMPLES(pin_event_pkg::WAKE_SAMPLES)) wake_qual
   (
      .clk_in      (CLK_IN),
      .rst_b_in    (RST_B_IN),
      .wdt_tick_in (wdt_tick),
      .armed_in    (wake_armed),
      .level_ok_in (wake_level_ok),
      .wake_out    (WAKE_OUT)
   );

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign EXT_FLAG_OUT       = ext_flag_r;
   assign EXT_IRQ_REQ_OUT    = (EXT_CFG_IN.ext_irq_en && ext_flag_r) || ext_level_req;
   assign PINCHG_FLAG_OUT    = pinchg_flag_r;
   assign PINCHG_IRQ_REQ_OUT = pinchg_flag_r
                               && (PINCHG_UPPER_GROUP_EN_IN || PINCHG_LOWER_GROUP_EN_IN);

endmodule
`default_nettype wire

/* verification/pin_event_properties.sv */
// port level assertions for the pin event interrupt logic
`timescale 1ns/1ps
`default_nettype none
module pin_event_checker
(
   input wire logic                    CLK_IN,
   input wire logic                    RST_B_IN,
   input wire logic [7:0]              PORT_A_IN,
   input wire logic [7:0]              PORT_B_IN,
   input wire logic                    EXT_IRQ_LINE_IN,
   input wire pin_event_pkg::ext_cfg_t EXT_CFG_IN,
   input wire logic                    PINCHG_UPPER_GROUP_EN_IN,
   input wire logic                    PINCHG_LOWER_GROUP_EN_IN,
   input wire logic                    EXT_FLAG_CLEAR_IN,
   input wire logic                    EXT_VECTOR_TAKEN_IN,
   input wire logic                    PINCHG_FLAG_CLEAR_IN,
   input wire logic                    PINCHG_VECTOR_TAKEN_IN,
   input wire logic                    SLEEP_IN,
   input wire logic                    EXT_FLAG_OUT,
   input wire logic                    EXT_IRQ_REQ_OUT,
   input wire logic                    PINCHG_FLAG_OUT,
   input wire logic                    PINCHG_IRQ_REQ_OUT,
   input wire logic                    WAKE_OUT
);
   logic grp_en;
   assign grp_en = PINCHG_UPPER_GROUP_EN_IN | PINCHG_LOWER_GROUP_EN_IN;

   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   ////////////////////////////////////////
   // six quiet cycles leave no change in the synchroniser
   sequence s_pins_quiet;
      ($stable(PORT_A_IN) && $stable(PORT_B_IN)) [*6];
   endsequence
   sequence s_held_low;
      (EXT_CFG_IN == 3'h4 && !EXT_IRQ_LINE_IN) [*4];
   endsequence
   sequence s_disarmed;
      !(SLEEP_IN && EXT_CFG_IN.ext_irq_en) [*3];
   endsequence

   ////////////////////////////////////////
   property p_pin_req;
      PINCHG_IRQ_REQ_OUT == (PINCHG_FLAG_OUT && grp_en);
   endproperty
   property p_pin_hold;
      PINCHG_FLAG_OUT && !PINCHG_FLAG_CLEAR_IN && !PINCHG_VECTOR_TAKEN_IN
         |=> PINCHG_FLAG_OUT;
   endproperty
   property p_pin_clear;
      s_pins_quiet ##0 (PINCHG_FLAG_CLEAR_IN || PINCHG_VECTOR_TAKEN_IN) |=> !PINCHG_FLAG_OUT;
   endproperty
   property p_pin_group;
      $rose(PINCHG_FLAG_OUT) |-> $past(grp_en);
   endproperty
   property p_ext_level_flag;
      EXT_CFG_IN.sense == pin_event_pkg::SENSE_LOW |=> !EXT_FLAG_OUT;
   endproperty
   property p_ext_hold;
      EXT_FLAG_OUT && !EXT_FLAG_CLEAR_IN && !EXT_VECTOR_TAKEN_IN
         && EXT_CFG_IN.sense != pin_event_pkg::SENSE_LOW |=> EXT_FLAG_OUT;
   endproperty
   property p_ext_level_req;
      s_held_low |-> EXT_IRQ_REQ_OUT;
   endproperty
   property p_ext_req_en;
      EXT_IRQ_REQ_OUT |-> EXT_CFG_IN.ext_irq_en;
   endproperty
   property p_wake_arm;
      s_disarmed |-> !WAKE_OUT;
   endproperty

   ////////////////////////////////////////
   a_pin_req: assert property (p_pin_req)
      else $error("pin request differs from flag and enable");
   a_pin_hold: assert property (p_pin_hold)
      else $error("pin flag dropped without clear");
   a_pin_clear: assert property (p_pin_clear)
      else $error("pin flag kept after clear");
   a_pin_group: assert property (p_pin_group)
      else $error("pin flag set with both groups off");
   a_ext_level_flag: assert property (p_ext_level_flag)
      else $error("ext flag set in level mode");
   a_ext_hold: assert property (p_ext_hold)
      else $error("ext flag dropped without clear");
   a_ext_level_req: assert property (p_ext_level_req)
      else $error("no ext request while line held low");
   a_ext_req_en: assert property (p_ext_req_en)
      else $error("ext request while disabled");
   a_wake_arm: assert property (p_wake_arm)
      else $error("wake while not armed");
endmodule

bind pin_event_interrupt_logic pin_event_checker pin_event_checker_inst
(
   .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .PORT_A_IN(PORT_A_IN), .PORT_B_IN(PORT_B_IN),
   .EXT_IRQ_LINE_IN(EXT_IRQ_LINE_IN), .EXT_CFG_IN(EXT_CFG_IN),
   .PINCHG_UPPER_GROUP_EN_IN(PINCHG_UPPER_GROUP_EN_IN),
   .PINCHG_LOWER_GROUP_EN_IN(PINCHG_LOWER_GROUP_EN_IN),
   .EXT_FLAG_CLEAR_IN(EXT_FLAG_CLEAR_IN), .EXT_VECTOR_TAKEN_IN(EXT_VECTOR_TAKEN_IN),
   .PINCHG_FLAG_CLEAR_IN(PINCHG_FLAG_CLEAR_IN),
   .PINCHG_VECTOR_TAKEN_IN(PINCHG_VECTOR_TAKEN_IN), .SLEEP_IN(SLEEP_IN),
   .EXT_FLAG_OUT(EXT_FLAG_OUT), .EXT_IRQ_REQ_OUT(EXT_IRQ_REQ_OUT),
   .PINCHG_FLAG_OUT(PINCHG_FLAG_OUT), .PINCHG_IRQ_REQ_OUT(PINCHG_IRQ_REQ_OUT),
   .WAKE_OUT(WAKE_OUT)
);
`default_nettype wire

/* verification/core_wdt_model.sv */
// watchdog oscillator and core vector entry model
`timescale 1ns/1ps
`default_nettype none
module core_wdt_model
(
   input  wire logic [1:0] ack_en_in,
   input  wire logic       clk_in,
   input  wire logic [1:0] irq_req_in,
   output logic      [1:0] vector_taken_out,
   output logic            wdt_tick_out
);
   // free running, about 1 us period, no phase tie to the system clock
   initial
   begin
      wdt_tick_out = 1'b0;
      forever #500.3 wdt_tick_out = ~wdt_tick_out;
   end

   // one cycle vector entry per pending request while accepting
   initial
   begin
      vector_taken_out = 2'h0;
      forever @(posedge clk_in) vector_taken_out <= ack_en_in & irq_req_in & ~vector_taken_out;
   end
endmodule
`default_nettype wire

/* verification/pin_event_interrupt_logic_tb.sv */
// self-checking bench for the pin event interrupt logic
`timescale 1ns/1ps
`default_nettype none
module pin_event_interrupt_logic_tb;
   logic                     clk      = 1'b0;
   logic                     rst_b    = 1'b0;
   logic [7:0]               pa       = 8'hff;
   logic [7:0]               pb       = 8'hff;
   logic                     ext_line = 1'b1;
   pin_event_pkg::ext_cfg_t  cfg      = '0;
   pin_event_pkg::alt_ctrl_t alt      = '0;
   logic                     up_en    = 1'b0;
   logic                     lo_en    = 1'b0;
   logic                     ext_clr  = 1'b0;
   logic                     pin_clr  = 1'b0;
   logic                     sleep    = 1'b0;
   logic [1:0]               ack      = 2'h0;
   logic [1:0]               vec;
   logic                     tick;
   logic                     ext_flag;
   logic                     ext_req;
   logic                     pin_flag;
   logic                     pin_req;
   logic                     wake;
   logic [10:0]              m;
   logic                     exp;
   int                       n_errors = 0;
   int                       checks   = 0;
   int                       seed     = 9711;
   int                       r;
   int                       idx;
   int                       pa_pos [3] = '{3, 6, 7};

   always #4 clk = ~clk;

   pin_event_interrupt_logic pin_event_interrupt_logic_inst
   (
      .CLK_IN(clk), .RST_B_IN(rst_b), .PORT_A_IN(pa), .PORT_B_IN(pb),
      .EXT_IRQ_LINE_IN(ext_line), .EXT_CFG_IN(cfg), .PINCHG_UPPER_GROUP_EN_IN(up_en),
      .PINCHG_LOWER_GROUP_EN_IN(lo_en), .ALT_CTRL_IN(alt), .EXT_FLAG_CLEAR_IN(ext_clr),
      .EXT_VECTOR_TAKEN_IN(vec[1]), .PINCHG_FLAG_CLEAR_IN(pin_clr),
      .PINCHG_VECTOR_TAKEN_IN(vec[0]), .SLEEP_IN(sleep), .WDT_TICK_IN(tick),
      .EXT_FLAG_OUT(ext_flag), .EXT_IRQ_REQ_OUT(ext_req), .PINCHG_FLAG_OUT(pin_flag),
      .PINCHG_IRQ_REQ_OUT(pin_req), .WAKE_OUT(wake)
   );
   core_wdt_model core_wdt_model_inst
   (
      .ack_en_in(ack), .clk_in(clk), .irq_req_in({ext_req, pin_req}),
      .vector_taken_out(vec), .wdt_tick_out(tick)
   );

   ////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk(input string what, input logic e, input logic got);
      checks++;
      if (got !== e)
      begin
         n_errors++;
         $display("unexpected %s: expected %b, seen %b", what, e, got);
      end
   endtask

   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // index 0-7 port b lines, 8-10 port a lines 3, 6, 7
   function automatic logic [10:0] masks(input pin_event_pkg::alt_ctrl_t a,
                                         input pin_event_pkg::ext_cfg_t  e);
      logic [4:0] code;
      logic       tw;
      code = {a.pll_clock_fuse, a.clock_select_fuses};
      tw   = !a.serial_wire_mode_hi && a.serial_wire_mode_lo;
      masks[0] = a.serial_wire_mode_hi || tw
         || {a.chan_a_compare_mode_hi, a.chan_a_compare_mode_lo, a.chan_a_pwm_en} == 3'h3;
      masks[1] = tw || a.chan_a_compare_mode_hi || a.chan_a_compare_mode_lo;
      masks[2] = a.serial_wire_mode_hi || tw
         || {a.chan_b_compare_mode_hi, a.chan_b_compare_mode_lo, a.chan_b_pwm_en} == 3'h3;
      masks[3] = a.chan_b_compare_mode_hi || a.chan_b_compare_mode_lo;
      masks[4] = code == 5'h10 || code >= 5'h15;
      masks[5] = code >= 5'h19;
      masks[6] = e == 3'h4 || (a.t0_clock_sel2 && a.t0_clock_sel1);
      masks[7] = a.reset_pin_disable_fuse;
      masks[8] = a.analog_ref_select;
      masks[9] = !a.comparator_disable;
      masks[10] = !a.comparator_disable;
   endfunction

   ////////////////////////////////////////
   initial
   begin
      step(16);
      rst_b = 1'b1;
      step(4);
      for (int i = 0; i < 200; i++)
      begin
         r     = $random(seed);
         alt   = r[$bits(alt)-1:0];
         cfg   = r[27:25];
         up_en = r[28];
         lo_en = r[29];
         r     = $random(seed);
         idx   = r[7:0] % 11;
         m     = masks(alt, cfg);
         exp   = !m[idx] && (idx < 4 ? lo_en : up_en);
         if (idx < 8)
            pb[idx] = ~pb[idx];
         else
            pa[pa_pos[idx-8]] = ~pa[pa_pos[idx-8]];
         step(6);
         chk("pin flag", exp, pin_flag);
         chk("pin request", exp, pin_req);
         pin_clr = i[0];
         ack[0]  = !i[0];
         step(1);
         pin_clr = 1'b0;
         step(3);
         ack[0] = 1'b0;
         chk("pin flag cleared", 1'b0, pin_flag);
      end
      $display("pin change test done");
      alt   = '0;
      up_en = 1'b1;
      for (int s = 1; s < 4; s++)
         for (int v = 0; v < 2; v++)
         begin
            cfg      = {1'b1, s[1:0]};
            ext_line = v[0];
            pb[6]    = ~pb[6];
            exp      = s == 1 || s == 2 + v;
            step(6);
            chk("ext flag", exp, ext_flag);
            chk("ext request", exp, ext_req);
            chk("pin flag from ext line", 1'b1, pin_flag);
            ext_clr = v[0];
            pin_clr = v[0];
            ack     = {!v[0], !v[0]};
            step(1);
            ext_clr = 1'b0;
            pin_clr = 1'b0;
            step(3);
            ack = 2'h0;
            chk("ext flag cleared", 1'b0, ext_flag);
         end
      $display("edge sense test done");
      cfg      = {1'b1, pin_event_pkg::SENSE_LOW};
      ext_line = 1'b0;
      step(5);
      repeat (3)
      begin
         chk("level request", 1'b1, ext_req);
         chk("level flag", 1'b0, ext_flag);
         step(1);
      end
      ext_line = 1'b1;
      step(5);
      chk("level request released", 1'b0, ext_req);
      cfg      = {1'b0, pin_event_pkg::SENSE_LOW};
      ext_line = 1'b0;
      step(5);
      chk("disabled request", 1'b0, ext_req);
      $display("level sense test done");
      cfg      = {1'b1, pin_event_pkg::SENSE_LOW};
      ext_line = 1'b1;
      sleep    = 1'b1;
      step(8);
      @(posedge tick);
      step(8);
      ext_line = 1'b0;
      @(posedge tick);
      step(8);
      chk("wake after one sample", 1'b0, wake);
      @(posedge tick);
      step(8);
      chk("wake after two samples", 1'b1, wake);
      sleep = 1'b0;
      step(3);
      chk("wake disarmed", 1'b0, wake);
      $display("wake test done");
      summarize();
   end

   // whole run needs about 20 us
   initial
   begin
      #100us;
      n_errors++;
      $display("unexpected timeout: expected finish, seen hang");
      summarize();
   end
endmodule
`default_nettype wire
